// file: dps_ctl_model.sv
/* Outside controller driving the profile pins and update strobe.
   Assumes the sync output changes on the core clock rising edge. */
`timescale 1ns/100ps
module dps_ctl_model
(
	input  wire logic       i_clk,
	input  wire logic       i_sync,
	input  wire logic [1:0] i_sel,
	input  wire logic       i_upd,
	output logic            o_psl,
	output logic            o_psh,
	output logic            o_fud
);
	logic sync_q; // Sync level at last falling edge
	initial
	begin
		sync_q = 1'b0;
		{o_psh, o_psl, o_fud} = 3'h0;
	end
	// Move pins just after a sync rise so the next rise sees them settled
	always @(negedge i_clk)
	begin
		sync_q <= i_sync;
		if (i_sync && !sync_q)
		begin
			{o_psh, o_psl} <= i_sel;
			o_fud <= i_upd;
		end
	end
endmodule

// file: dps_defines.vh
/*
 * Shared constants of the profile and sweep control block: byte
 * addresses, control bit positions, reset values and timing figures.
 * Assumes it is included by bare name into each design file.
 */
//
// Functional notes
// - Ramp interval is 16 bits at 0x08/0x09.
// - Timer ticks sweep accumulator every interval cycles.
// - Two select pins pick profile 0 to 3.
// - Each profile holds tuning and offset words.
// - Phase accumulator adds tuning word every cycle unless phase clear bit set.
// - Tuning word from profile, or sweep in sweep.
// - Offset added as fraction of full cycle.
// - Profile change swaps tuning and offset together.
// - Idle profiles writable; used once selected.
// - Selected profile writes wait for update strobe.
// - Offset path carries one extra register stage.
// - Selects sampled on sync clock rising edge.
// - Profile hops supported up to clock/8.
// - Sweep enable bit: clear tone, set sweep.
// - Signed step accumulated per tick, added to word.
// - Timer load bit adds update-strobe reload to timeout reload.
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH

// =====================================================================
// Byte addresses
`define DPS_ADDR_CTRL0      8'h00
`define DPS_ADDR_CTRL3      8'h03
`define DPS_ADDR_STEP0      8'h04
`define DPS_ADDR_STEP3      8'h07
`define DPS_ADDR_RAMP_LO    8'h08
`define DPS_ADDR_RAMP_HI    8'h09
`define DPS_ADDR_PROF_BASE  8'h0A
`define DPS_PROF_STRIDE     8'h06
`define DPS_PROF_POW_LO     8'h04
`define DPS_PROF_POW_HI     8'h05
`define DPS_ADDR_STATUS     8'h22

// =====================================================================
// Control register bits and reset value
`define DPS_CFR_CLR_PHASE   19
`define DPS_CFR_CLR_FREQ    20
`define DPS_CFR_TIMER_LOAD  21
`define DPS_CFR_SWEEP_EN    15
`define DPS_CFR_RESET       32'h0020_0018

// =====================================================================
// Timing: sync clock is the core clock divided by eight
`define DPS_SYNC_DIV        4'h8
`define DPS_SYNC_HALF       3'h4

`endif

// file: dps_profile_sweep.v
/*
 * Profile selection, tuning-word sweep and phase accumulation of the
 * synthesis core, with a byte-wide register write/read port.
 * Assumes the register port is on the core clock; the select pins and
 * update strobe come from outside and are synchronised here.
 */
`timescale 1ns/100ps
`include "dps_defines.vh"

module dps_profile_sweep
#(
	parameter NPROF = 4,
	parameter FTW_W = 32,
	parameter POW_W = 14
)
(
	input  wire             i_clk,
	input  wire             i_reset,
	input  wire             i_wr_en,
	input  wire [7:0]       i_wr_addr,
	input  wire [7:0]       i_wr_data,
	input  wire [7:0]       i_rd_addr,
	output reg  [7:0]       o_rd_data,
	input  wire             i_profile_select_low,
	input  wire             i_profile_select_high,
	input  wire             i_frequency_update_strobe,
	output reg              o_sync_clock_out,
	output reg  [1:0]       o_active_profile,
	output reg  [FTW_W-1:0] o_tuning_word,
	output reg  [POW_W-1:0] o_phase,
	output reg              o_ramp_tick
);

	// =================================================================
	// Storage
	reg [31:0]       control_function_register_r;  // Mode bits
	reg [31:0]       sweep_step_word_r;            // Signed sweep step
	reg [15:0]       sweep_ramp_interval_r;        // Ramp interval
	reg [FTW_W-1:0]  prof_ftw_r [0:NPROF-1];       // Per-profile words
	reg [POW_W-1:0]  prof_pow_r [0:NPROF-1];       // Per-profile offsets

	// Live working set
	reg [FTW_W-1:0]  act_ftw_r;      // Active tuning word
	reg [POW_W-1:0]  act_pow_r;      // Active phase offset
	reg [POW_W-1:0]  pow_dly_r;      // Offset unit delay
	reg [FTW_W-1:0]  freq_acc_r;     // Sweep accumulator
	reg [FTW_W-1:0]  ftw_eff_r;      // Word fed to phase accumulator
	reg [FTW_W-1:0]  phase_acc_r;    // Phase accumulator

	// Synchronisers, two flops each before any use
	reg [1:0]        ps_meta_r;      // First stage, selects
	reg [1:0]        ps_sync_r;      // Second stage, selects
	reg              fud_meta_r;     // First stage, update
	reg              fud_sync_r;     // Second stage, update
	reg              fud_prev_r;     // For edge detect

	reg [2:0]        div_cnt_r;      // Sync clock divider
	wire             sync_rise;      // Sync clock about to rise
	wire             fud_pulse;      // Update strobe rising edge
	wire             tick;           // Ramp tick from timer
	wire             sweep_en;       // Sweep mode
	wire [1:0]       sel_now;        // Select bits as a number

	assign sweep_en  = control_function_register_r[`DPS_CFR_SWEEP_EN];
	assign fud_pulse = fud_sync_r & ~fud_prev_r;
	assign sync_rise = (div_cnt_r == `DPS_SYNC_HALF - 3'h1);
	assign sel_now   = ps_sync_r;

	// =================================================================
	// Input synchronisers
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			ps_meta_r  <= 2'h0;
			ps_sync_r  <= 2'h0;
			fud_meta_r <= 1'b0;
			fud_sync_r <= 1'b0;
			fud_prev_r <= 1'b0;
		end
		else
		begin
			// High pin is the high bit of the profile number
			ps_meta_r  <= {i_profile_select_high, i_profile_select_low};
			ps_sync_r  <= ps_meta_r;
			fud_meta_r <= i_frequency_update_strobe;
			fud_sync_r <= fud_meta_r;
			fud_prev_r <= fud_sync_r;
		end
	end

	// =================================================================
	// Sync clock out: core clock over eight, sets the hop rate ceiling
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			div_cnt_r        <= 3'h0;
			o_sync_clock_out <= 1'b0;
		end
		else
		begin
			div_cnt_r <= div_cnt_r + 3'h1;
			if (sync_rise)
				o_sync_clock_out <= 1'b1;
			else if ({1'b0, div_cnt_r} == `DPS_SYNC_DIV - 4'h1)
				o_sync_clock_out <= 1'b0;
		end
	end

	// =================================================================
	// Global register writes
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			control_function_register_r <= `DPS_CFR_RESET;
			sweep_step_word_r           <= 32'h0000_0000;
			sweep_ramp_interval_r       <= 16'h0000;
		end
		else if (i_wr_en)
		begin
			case (i_wr_addr)
				8'h00: control_function_register_r[7:0]   <= i_wr_data;
				8'h01: control_function_register_r[15:8]  <= i_wr_data;
				8'h02: control_function_register_r[23:16] <= i_wr_data;
				8'h03: control_function_register_r[31:24] <= i_wr_data;
				8'h04: sweep_step_word_r[7:0]             <= i_wr_data;
				8'h05: sweep_step_word_r[15:8]            <= i_wr_data;
				8'h06: sweep_step_word_r[23:16]           <= i_wr_data;
				`DPS_ADDR_STEP3: sweep_step_word_r[31:24] <= i_wr_data;
				// Low byte then high byte of the interval
				`DPS_ADDR_RAMP_LO:
					sweep_ramp_interval_r[7:0]  <= i_wr_data;
				`DPS_ADDR_RAMP_HI:
					sweep_ramp_interval_r[15:8] <= i_wr_data;
				default: ;
			endcase
		end
	end

	// =================================================================
	// Profile storage, one block per profile; writes never touch the
	// live working set, so idle profiles load freely
	genvar gp;
	generate
		for (gp = 0; gp < NPROF; gp = gp + 1)
		begin : g_prof
			// First byte address of this profile
			localparam integer PBASE = `DPS_ADDR_PROF_BASE
			                           + gp * `DPS_PROF_STRIDE;
			wire [7:0] off;   // Address relative to this profile
			assign off = i_wr_addr - PBASE[7:0];
			always @(posedge i_clk)
			begin
				if (i_reset)
				begin
					prof_ftw_r[gp] <= {FTW_W{1'b0}};
					prof_pow_r[gp] <= {POW_W{1'b0}};
				end
				else if (i_wr_en && off < `DPS_PROF_STRIDE)
				begin
					case (off)
						8'h00: prof_ftw_r[gp][7:0]   <= i_wr_data;
						8'h01: prof_ftw_r[gp][15:8]  <= i_wr_data;
						8'h02: prof_ftw_r[gp][23:16] <= i_wr_data;
						8'h03: prof_ftw_r[gp][31:24] <= i_wr_data;
						`DPS_PROF_POW_LO:
							prof_pow_r[gp][7:0] <= i_wr_data;
						`DPS_PROF_POW_HI:
							prof_pow_r[gp][13:8] <= i_wr_data[5:0];
						default: ;
					endcase
				end
			end
		end
	endgenerate

	// =================================================================
	// Active profile: new select at sync edge, or update strobe reload
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_active_profile <= 2'h0;
			act_ftw_r        <= {FTW_W{1'b0}};
			act_pow_r        <= {POW_W{1'b0}};
		end
		else if (sync_rise && sel_now != o_active_profile)
		begin
			// Both words move in the same cycle
			o_active_profile <= sel_now;
			act_ftw_r        <= prof_ftw_r[sel_now];
			act_pow_r        <= prof_pow_r[sel_now];
		end
		else if (fud_pulse)
		begin
			// Writes to the live profile wait for the strobe
			act_ftw_r <= prof_ftw_r[o_active_profile];
			act_pow_r <= prof_pow_r[o_active_profile];
		end
	end

	// =================================================================
	// Ramp timer
	dps_ramp_timer #(.WIDTH(16)) u_ramp
	(
		.i_clk            (i_clk),
		.i_reset          (i_reset),
		.i_interval       (sweep_ramp_interval_r),
		.i_load_on_update
			(control_function_register_r[`DPS_CFR_TIMER_LOAD]),
		.i_update         (fud_pulse),
		.o_tick           (tick)
	);

	// =================================================================
	// Sweep accumulator and effective tuning word
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			freq_acc_r  <= {FTW_W{1'b0}};
			ftw_eff_r   <= {FTW_W{1'b0}};
			o_ramp_tick <= 1'b0;
		end
		else
		begin
			o_ramp_tick <= tick;
			// Tone mode or clear bit keeps the sweep at zero
			if (!sweep_en
			    || control_function_register_r[`DPS_CFR_CLR_FREQ])
				freq_acc_r <= {FTW_W{1'b0}};
			else if (tick)
				freq_acc_r <= freq_acc_r + sweep_step_word_r;
			if (sweep_en)
				ftw_eff_r <= act_ftw_r + freq_acc_r;
			else
				ftw_eff_r <= act_ftw_r;
		end
	end

	// =================================================================
	// Phase accumulator and offset; the unit delay evens latency
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			phase_acc_r   <= {FTW_W{1'b0}};
			pow_dly_r     <= {POW_W{1'b0}};
			o_phase       <= {POW_W{1'b0}};
			o_tuning_word <= {FTW_W{1'b0}};
		end
		else
		begin
			if (control_function_register_r[`DPS_CFR_CLR_PHASE])
				phase_acc_r <= {FTW_W{1'b0}};
			else
				phase_acc_r <= phase_acc_r + ftw_eff_r;
			pow_dly_r     <= act_pow_r;
			// Offset weighs offset/2^14 of a cycle: top 14 bits
			o_phase       <= phase_acc_r[FTW_W-1:FTW_W-POW_W]
			                 + pow_dly_r;
			o_tuning_word <= ftw_eff_r;
		end
	end

	// =================================================================
	// Register read port, one cycle latency
	always @(posedge i_clk)
	begin : rd_blk
		integer p;
		if (i_reset)
			o_rd_data <= 8'h00;
		else
		begin
			o_rd_data <= 8'h00;
			case (i_rd_addr)
				8'h00: o_rd_data <= control_function_register_r[7:0];
				8'h01: o_rd_data <= control_function_register_r[15:8];
				8'h02: o_rd_data <= control_function_register_r[23:16];
				8'h03: o_rd_data <= control_function_register_r[31:24];
				8'h04: o_rd_data <= sweep_step_word_r[7:0];
				8'h05: o_rd_data <= sweep_step_word_r[15:8];
				8'h06: o_rd_data <= sweep_step_word_r[23:16];
				8'h07: o_rd_data <= sweep_step_word_r[31:24];
				8'h08: o_rd_data <= sweep_ramp_interval_r[7:0];
				8'h09: o_rd_data <= sweep_ramp_interval_r[15:8];
				`DPS_ADDR_STATUS:
					o_rd_data <= {5'h00, sweep_en, o_active_profile};
				default: ;
			endcase
			for (p = 0; p < NPROF; p = p + 1)
			begin
				// Offset inside profile p; other addresses wrap high
				case (i_rd_addr - (`DPS_ADDR_PROF_BASE
				      + p[7:0] * `DPS_PROF_STRIDE))
					8'h00: o_rd_data <= prof_ftw_r[p][7:0];
					8'h01: o_rd_data <= prof_ftw_r[p][15:8];
					8'h02: o_rd_data <= prof_ftw_r[p][23:16];
					8'h03: o_rd_data <= prof_ftw_r[p][31:24];
					8'h04: o_rd_data <= prof_pow_r[p][7:0];
					8'h05: o_rd_data <= {2'h0, prof_pow_r[p][13:8]};
					default: ;
				endcase
			end
		end
	end

endmodule

// file: dps_ramp_timer.v
/*
 * Ramp-rate down counter: issues one tick each time the programmed
 * number of core cycles has passed.
 * Assumes the update pulse is already on the core clock.
 */
`timescale 1ns/100ps
`include "dps_defines.vh"

module dps_ramp_timer
#(
	parameter WIDTH = 16
)
(
	input  wire             i_clk,
	input  wire             i_reset,
	input  wire [WIDTH-1:0] i_interval,
	input  wire             i_load_on_update,
	input  wire             i_update,
	output reg              o_tick
);

	reg [WIDTH-1:0] count_r;   // Cycles left until next tick
	wire            timeout;   // Counter at its last cycle
	wire [WIDTH-1:0] reload;   // Interval less one, zero held at zero

	assign timeout = (count_r == {WIDTH{1'b0}});
	// Zero behaves as one so the tick never stalls
	assign reload  = (i_interval == {WIDTH{1'b0}}) ? {WIDTH{1'b0}}
	                 : i_interval - {{(WIDTH-1){1'b0}}, 1'b1};

	// =================================================================
	// Down counter with reload
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			count_r <= {WIDTH{1'b0}};
			o_tick  <= 1'b0;
		end
		else
		begin
			o_tick <= timeout;
			if (i_load_on_update && i_update)
				count_r <= reload;
			else if (timeout)
				count_r <= reload;
			else
				count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule

// file: dps_sweep_monitor.sv
/* Port checker for the profile and sweep block.
   Assumes one core clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module dps_sweep_monitor
#(
	parameter FTW_W = 32,
	parameter POW_W = 14
)
(
	input wire logic             i_clk,
	input wire logic             i_reset,
	input wire logic             i_wr_en,
	input wire logic [7:0]       i_wr_addr,
	input wire logic [7:0]       i_wr_data,
	input wire logic [7:0]       i_rd_addr,
	input wire logic [7:0]       o_rd_data,
	input wire logic             i_profile_select_low,
	input wire logic             i_profile_select_high,
	input wire logic             i_frequency_update_strobe,
	input wire logic             o_sync_clock_out,
	input wire logic [1:0]       o_active_profile,
	input wire logic [FTW_W-1:0] o_tuning_word,
	input wire logic [POW_W-1:0] o_phase,
	input wire logic             o_ramp_tick
);
	// ==========
	// Shadow state
	logic [15:0] iv_r;  // Interval as last written
	logic [16:0] gap_r; // Cycles since last tick
	logic        ok_r;  // Gap undisturbed by writes or strobe
	logic [3:0]  fd_r;  // Recent strobe levels
	logic [2:0]  run_r; // Cycles the selects held still
	logic [1:0]  sel_r; // Selects one cycle ago
	logic [1:0]  wv_r;  // Recent interval writes
	wire  [1:0]  sel = {i_profile_select_high, i_profile_select_low};
	wire  [16:0] iv1 = (iv_r == 16'h0) ? 17'h1 : {1'b0, iv_r};
	wire         wiv = i_wr_en &&
		(i_wr_addr == 8'h08 || i_wr_addr == 8'h09);
	// Strobe edge restarts the timer a few cycles late, so look back four;
	// ticks already in flight lag a new interval by two more cycles
	wire         evt = (fd_r != {4{fd_r[0]}}) || wiv || (wv_r != 2'h0);
	// Helper registers
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			iv_r <= 16'h0;
			gap_r <= 17'h0;
			ok_r <= 1'b0;
			fd_r <= 4'h0;
			run_r <= 3'h0;
			sel_r <= 2'h0;
			wv_r <= 2'h0;
		end
		else
		begin
			if (i_wr_en && i_wr_addr == 8'h08)
				iv_r[7:0] <= i_wr_data;
			if (i_wr_en && i_wr_addr == 8'h09)
				iv_r[15:8] <= i_wr_data;
			gap_r <= o_ramp_tick ? 17'h1 : gap_r + 17'h1;
			ok_r <= !evt && (o_ramp_tick || ok_r);
			fd_r <= {fd_r[2:0], i_frequency_update_strobe};
			run_r <= (sel != sel_r) ? 3'h0 : (run_r == 3'h7) ? run_r : run_r + 3'h1;
			sel_r <= sel;
			wv_r <= {wv_r[0], wiv};
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// ==========
	// Properties
	property p_sync;
		$rose(o_sync_clock_out) |-> o_sync_clock_out[*4] ##1 !o_sync_clock_out[*4] ##1 o_sync_clock_out;
	endproperty
	property p_hop;
		$changed(o_active_profile) |-> $rose(o_sync_clock_out);
	endproperty
	property p_sel;
		$rose(o_sync_clock_out) && run_r >= 3'h5 |-> o_active_profile == sel_r;
	endproperty
	property p_gap;
		o_ramp_tick && ok_r |-> gap_r == iv1;
	endproperty
	property p_pulse;
		// Start of a tick only: a shorter old interval may still run out
		$rose(o_ramp_tick) && iv_r > 16'h1 |=> !o_ramp_tick;
	endproperty
	property p_unmap;
		i_rd_addr > 8'h22 |=> o_rd_data == 8'h00;
	endproperty
	property p_rdlo;
		i_rd_addr == 8'h08 && !i_wr_en |=> o_rd_data == iv_r[7:0];
	endproperty
	property p_rdhi;
		i_rd_addr == 8'h09 && !i_wr_en |=> o_rd_data == iv_r[15:8];
	endproperty
	property p_stat;
		i_rd_addr == 8'h22 ##1 $stable(o_active_profile) |-> o_rd_data[1:0] == o_active_profile;
	endproperty
	a_sync: assert property (p_sync) else $error("sync period wrong");
	a_hop: assert property (p_hop) else $error("hop off sync edge");
	a_sel: assert property (p_sel) else $error("wrong profile");
	a_gap: assert property (p_gap) else $error("tick spacing wrong");
	a_pulse: assert property (p_pulse) else $error("tick too long");
	a_unmap: assert property (p_unmap) else $error("unmapped not zero");
	a_rdlo: assert property (p_rdlo) else $error("interval low wrong");
	a_rdhi: assert property (p_rdhi) else $error("interval high wrong");
	a_stat: assert property (p_stat) else $error("status wrong");
	c_p3: cover property ($rose(o_sync_clock_out) && o_active_profile == 2'h3);
	c_gap: cover property (o_ramp_tick && ok_r);
	c_tw: cover property ($changed(o_tuning_word));
endmodule
bind dps_profile_sweep dps_sweep_monitor #(.FTW_W(FTW_W), .POW_W(POW_W)) u_mon
(
	.i_clk(i_clk), .i_reset(i_reset), .i_wr_en(i_wr_en),
	.i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr),
	.o_rd_data(o_rd_data), .i_profile_select_low(i_profile_select_low),
	.i_profile_select_high(i_profile_select_high),
	.i_frequency_update_strobe(i_frequency_update_strobe),
	.o_sync_clock_out(o_sync_clock_out), .o_active_profile(o_active_profile),
	.o_tuning_word(o_tuning_word), .o_phase(o_phase),
	.o_ramp_tick(o_ramp_tick)
);

// file: tb.sv
/* Self-checking bench for the profile and sweep block.
   Assumes the controller model and the bound port checker. */
`timescale 1ns/100ps
module tb;
	logic        i_clk = 1'b0;
	logic        i_reset = 1'b1;
	logic        i_wr_en = 1'b0;
	logic [7:0]  i_wr_addr = 8'h00;
	logic [7:0]  i_wr_data = 8'h00;
	logic [7:0]  i_rd_addr = 8'h00;
	logic [1:0]  sel_req = 2'h0; // Profile the controller should pick
	logic        upd_req = 1'b0; // Strobe level the controller should drive
	logic [31:0] t1;
	wire  [7:0]  o_rd_data;
	wire         psl, psh, frequency_update_strobe, o_sync_clock_out, o_ramp_tick;
	wire  [1:0]  o_active_profile;
	wire  [31:0] o_tuning_word;
	wire  [13:0] o_phase;
	int          n_mismatch = 0;
	int          checked = 0;
	always #5 i_clk = ~i_clk;
	dps_ctl_model u_ctl
	(
		.i_clk(i_clk), .i_sync(o_sync_clock_out), .i_sel(sel_req),
		.i_upd(upd_req), .o_psl(psl), .o_psh(psh), .o_fud(frequency_update_strobe)
	);
	dps_profile_sweep u_dut
	(
		.i_clk(i_clk), .i_reset(i_reset), .i_wr_en(i_wr_en),
		.i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr),
		.o_rd_data(o_rd_data), .i_profile_select_low(psl),
		.i_profile_select_high(psh), .i_frequency_update_strobe(frequency_update_strobe),
		.o_sync_clock_out(o_sync_clock_out), .o_active_profile(o_active_profile),
		.o_tuning_word(o_tuning_word), .o_phase(o_phase),
		.o_ramp_tick(o_ramp_tick)
	);
	// ==========
	// Shared tasks
	task automatic final_report();
		$display("compared %0d mismatched %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		{i_wr_en, i_wr_addr, i_wr_data} = {1'b1, a, d};
		@(negedge i_clk);
		i_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge i_clk);
		i_rd_addr = a;
		@(negedge i_clk);
		chk("rd_data", {24'h0, e}, {24'h0, o_rd_data});
	endtask
	// Bounded wait on the profile (k=0), tuning word (k=1) or tick (k=2)
	task automatic wait_on(input int k, input logic [31:0] e);
		for (int i = 0; i < 64; i++)
		begin
			@(negedge i_clk);
			if (k == 0 ? o_active_profile === e[1:0] : k == 1 ?
				o_tuning_word === e : o_ramp_tick === 1'b1)
				return;
		end
		n_mismatch++;
		final_report();
	endtask
	// Profile words: profile 0 steps the phase by exactly one per cycle
	function automatic logic [31:0] frequency_tuning_word(input logic [1:0] p);
		return (({30'h0, p} + 32'h1) << 18) | {30'h0, p};
	endfunction
	function automatic logic [13:0] pw(input logic [1:0] p);
		return {p, 12'hA5C};
	endfunction
	// ==========
	// Scenarios
	task automatic t_regs();
		rd(8'h02, 8'h20);
		wr(8'h08, 8'h34);
		wr(8'h09, 8'h12);
		rd(8'h08, 8'h34);
		rd(8'h09, 8'h12);
		rd(8'h30, 8'h00);
	endtask
	task automatic t_prof();
		logic [7:0] b;
		wr(8'h02, 8'h28); // Hold phase accumulator clear: phase shows offset
		for (int p = 0; p < 4; p++)
		begin
			b = 8'h0A + 8'(p) * 8'h06;
			for (int k = 0; k < 4; k++)
				wr(b + 8'(k), frequency_tuning_word(2'(p)) >> (8 * k));
			wr(b + 8'h04, pw(2'(p)) & 14'hFF);
			wr(b + 8'h05, {2'b0, pw(2'(p)) >> 8});
		end
		for (int p = 3; p >= 0; p--)
		begin
			sel_req = 2'(p);
			wait_on(0, p);
			repeat (4) @(negedge i_clk);
			chk("tuning", frequency_tuning_word(2'(p)), o_tuning_word);
			chk("phase", {18'h0, pw(2'(p))}, {18'h0, o_phase});
		end
	endtask
	task automatic t_acc();
		wr(8'h02, 8'h20);
		repeat (4) @(negedge i_clk);
		t1 = {18'h0, o_phase};
		@(negedge i_clk);
		chk("phase_step", 32'h1, {18'h0, o_phase - t1[13:0]});
	endtask
	task automatic t_upd();
		wr(8'h0B, 8'h77);
		wr(8'h16, 8'h55);
		repeat (20) @(negedge i_clk);
		chk("held", frequency_tuning_word(2'h0), o_tuning_word);
		upd_req = 1'b1;
		wait_on(1, 32'h0004_7700);
		chk("updated", 32'h0004_7700, o_tuning_word);
		upd_req = 1'b0;
		sel_req = 2'h2;
		wait_on(0, 2);
		repeat (4) @(negedge i_clk);
		chk("idle_write", frequency_tuning_word(2'h2) & 32'hFFFF_FF00 | 32'h55, o_tuning_word);
		rd(8'h22, 8'h02);
	endtask
	task automatic t_sweep();
		wr(8'h04, 8'h01);
		wr(8'h08, 8'h03);
		wr(8'h09, 8'h00);
		wr(8'h01, 8'h80);
		rd(8'h22, 8'h06);
		// Timer still runs the long interval: strobe restarts it
		upd_req = 1'b1;
		repeat (16) @(negedge i_clk);
		upd_req = 1'b0;
		wait_on(2, 0);
		t1 = o_tuning_word;
		@(negedge i_clk);
		wait_on(2, 0);
		chk("sweep_step", t1 + 32'h1, o_tuning_word);
		wr(8'h01, 8'h00);
		repeat (4) @(negedge i_clk);
		chk("tone", frequency_tuning_word(2'h2) & 32'hFFFF_FF00 | 32'h55, o_tuning_word);
		// Clear bit holds the sweep at zero even in sweep mode
		wr(8'h02, 8'h10);
		wr(8'h01, 8'h80);
		repeat (8) @(negedge i_clk);
		chk("sweep_clear", frequency_tuning_word(2'h2) & 32'hFFFF_FF00 | 32'h55, o_tuning_word);
	endtask
	// Main sequence
	initial
	begin
		repeat (12) @(negedge i_clk);
		i_reset = 1'b0;
		t_regs();
		t_prof();
		t_acc();
		t_upd();
		t_sweep();
		final_report();
	end
endmodule
